// [rtl/bamr_regs.svh]
// constants for the battery alarm and mode register bank
// assumes a 50 MHz core clock and word-level smbus transfers from outside
`ifndef BAMR_REGS_SVH
`define BAMR_REGS_SVH
`define BAMR_CLK_HZ        50000000
`define BAMR_DEV_ADDR      7'h0B
`define BAMR_HOST_ADDR     7'h10
`define BAMR_CHGR_ADDR     7'h12
`define BAMR_CMD_CAP_THR   8'h01
`define BAMR_CMD_TIME_THR  8'h02
`define BAMR_CMD_MODE      8'h03
`define BAMR_CMD_ALARM     8'h16
`define BAMR_CMD_CHG_CUR   8'h14
`define BAMR_CMD_CHG_VOLT  8'h15
`define BAMR_WARN_CAP_BIT  9
`define BAMR_WARN_TIME_BIT 8
`define BAMR_BIT_RELEARN   7
`define BAMR_BIT_ALARM_OFF 13
`define BAMR_BIT_CHG_OFF   14
`define BAMR_BIT_UNITS     15
`define BAMR_SUPPRESS_S    6'h3C
`define BAMR_BCAST_GAP_S   6'h0A
`define BAMR_RELEARN_CYC   5'h14
`endif

// [rtl/bamr_pkg.sv]
// types for the battery alarm and mode register bank
// assumes nothing beyond the constants header
package bamr_pkg;
  typedef enum logic [1:0]
  {
    BAMR_IDLE  = 2'b00,
    BAMR_ALARM = 2'b01,
    BAMR_CHG_I = 2'b10,
    BAMR_CHG_V = 2'b11
  } bamr_state_e;
endpackage : bamr_pkg

// [rtl/bamr_top.sv]
// battery alarm thresholds, mode word and broadcast scheduler
// assumes an smbus engine on the same clock that hands over decoded word
// transfers and performs master write-word messages one at a time
//
// Overview of operation
// - capacity below threshold sends capacity alarm
// - zero capacity threshold disables that alarm
// - capacity threshold loads from nonvolatile bytes 2-3
// - capacity threshold unsigned 16 bit, units bit
// - time below threshold sends time alarm
// - zero time threshold disables time alarm
// - time threshold loads from nonvolatile bytes 0-1
// - time threshold unsigned minutes, full range
// - mode bits 13-15 writable, bits 0-12 read-only
// - relearn set on reset/20 cycles, cleared learned
// - mode bits 8 and 9 forced zero
// - alarm suppress blocks mastering 59 to 60 s
// - suppress clear means alarms go out
// - alarm messages at least 10 s apart
// - mode command restarts 60 s re-enable timer
// - sleep clears bits 13, 14, 15
// - alarm suppress also blocks charger broadcasts
// - charger suppress stops charge requests
// - units bit selects mA or 10 mW
// - charger to 0x12, alarms to 0x10
// - master broadcasts use write word
// - host reaches registers at address 0001011
`timescale 1ns/10ps
`include "bamr_regs.svh"
module bamr_top
  import bamr_pkg::*;
#(
  parameter int unsigned CYC_PER_SEC = `BAMR_CLK_HZ
)
(
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  // nonvolatile data and life-cycle events
  input  wire logic        init_load_in,
  input  wire logic [15:0] nv_time_thr_in,
  input  wire logic [15:0] nv_cap_thr_in,
  input  wire logic        full_reset_in,
  input  wire logic        cycle_count_in,
  input  wire logic        fcc_update_in,
  input  wire logic        learn_done_in,
  input  wire logic        sleep_in,
  // measured values
  input  wire logic [15:0] remaining_capacity_value_in,
  input  wire logic [15:0] average_time_to_empty_in,
  input  wire logic [15:0] charge_current_request_in,
  input  wire logic [15:0] charge_voltage_request_in,
  // slave word transfers
  input  wire logic        cmd_valid_in,
  input  wire logic        cmd_write_in,
  input  wire logic [6:0]  cmd_addr_in,
  input  wire logic [7:0]  cmd_code_in,
  input  wire logic [15:0] cmd_wdata_in,
  output logic             cmd_done_out,
  output logic             cmd_ack_out,
  output logic [15:0]      cmd_rdata_out,
  // master write-word broadcasts
  output logic             mst_req_out,
  output logic [6:0]       mst_addr_out,
  output logic [7:0]       mst_cmd_out,
  output logic [15:0]      mst_data_out,
  input  wire logic        mst_done_in,
  // mode state for the rest of the gauge
  output logic             capacity_units_out
);

  function automatic logic is_below(input logic [15:0] val, input logic [15:0] thr);
    is_below = (thr != 16'h0000) && (val < thr);
  endfunction : is_below

  logic [15:0] cap_thr_q,    cap_thr_d;
  logic [15:0] time_thr_q,   time_thr_d;
  logic [2:0]  mode_hi_q,    mode_hi_d;
  logic        relearn_q,    relearn_d;
  logic [4:0]  cyc_cnt_q,    cyc_cnt_d;
  logic [31:0] presc_q,      presc_d;
  logic [5:0]  supp_s_q,     supp_s_d;
  logic [5:0]  alarm_gap_q,  alarm_gap_d;
  logic [5:0]  chg_gap_q,    chg_gap_d;
  bamr_state_e state_q,      state_d;
  logic        req_q,        req_d;
  logic [6:0]  addr_q,       addr_d;
  logic [7:0]  mcmd_q,       mcmd_d;
  logic [15:0] mdata_q,      mdata_d;
  logic        done_q, ack_q;
  logic [15:0] rdata_q;

  wire         sec_tick   = (presc_q == CYC_PER_SEC - 1);
  wire         to_me      = cmd_valid_in && (cmd_addr_in == `BAMR_DEV_ADDR);
  wire         hit_cap    = to_me && (cmd_code_in == `BAMR_CMD_CAP_THR);
  wire         hit_time   = to_me && (cmd_code_in == `BAMR_CMD_TIME_THR);
  wire         hit_mode   = to_me && (cmd_code_in == `BAMR_CMD_MODE);
  wire         hit_any    = hit_cap || hit_time || hit_mode;
  wire         wr_cap     = hit_cap && cmd_write_in;
  wire         wr_time    = hit_time && cmd_write_in;
  wire         wr_mode    = hit_mode && cmd_write_in;
  wire         alarm_off  = mode_hi_q[0];
  wire         chg_off    = mode_hi_q[1];
  wire [15:0]  mode_word  = {mode_hi_q, 5'h00, relearn_q, 7'h00};
  wire         cap_alarm  = is_below(remaining_capacity_value_in, cap_thr_q);
  wire         time_alarm = is_below(average_time_to_empty_in, time_thr_q);
  wire [15:0]  warn_word  = 16'(({15'h0000, cap_alarm} << `BAMR_WARN_CAP_BIT)
                              | ({15'h0000, time_alarm} << `BAMR_WARN_TIME_BIT));
  // gap counters saturate one above the limit so a full gap has surely passed
  wire         alarm_ok   = (alarm_gap_q > `BAMR_BCAST_GAP_S);
  wire         chg_ok     = (chg_gap_q > `BAMR_BCAST_GAP_S);
  wire [15:0]  rd_mux     = hit_cap  ? cap_thr_q :
                            hit_time ? time_thr_q :
                            hit_mode ? mode_word : 16'h0000;
  assign       presc_d    = sec_tick ? 32'h0000_0000 : presc_q + 32'h0000_0001;

  // thresholds: nonvolatile load, then host writes only
  always_comb
  begin
    cap_thr_d  = cap_thr_q;
    time_thr_d = time_thr_q;
    if (init_load_in)
    begin
      cap_thr_d  = nv_cap_thr_in;
      time_thr_d = nv_time_thr_in;
    end
    if (wr_cap)
      cap_thr_d = cmd_wdata_in;
    if (wr_time)
      time_thr_d = cmd_wdata_in;
  end

  // mode high byte, suppress timer and relearn flag
  always_comb
  begin
    mode_hi_d = mode_hi_q;
    supp_s_d  = supp_s_q;
    if (sec_tick && (supp_s_q != 6'h00))
      supp_s_d = supp_s_q - 6'h01;
    if (sec_tick && (supp_s_q == 6'h01))
      mode_hi_d[0] = 1'b0;
    if (hit_mode)
      supp_s_d = `BAMR_SUPPRESS_S;
    if (wr_mode)
      mode_hi_d = cmd_wdata_in[`BAMR_BIT_UNITS:`BAMR_BIT_ALARM_OFF];
    if (sleep_in)
      mode_hi_d = 3'b000;
    cyc_cnt_d = cyc_cnt_q;
    relearn_d = relearn_q;
    if (fcc_update_in)
      cyc_cnt_d = 5'h00;
    else if (cycle_count_in && (cyc_cnt_q != `BAMR_RELEARN_CYC))
      cyc_cnt_d = cyc_cnt_q + 5'h01;
    if (learn_done_in)
      relearn_d = 1'b0;
    // besides full reset, only the step onto the limit sets it, so a finished learn can clear it
    if (full_reset_in
        || ((cyc_cnt_d == `BAMR_RELEARN_CYC) && (cyc_cnt_q != `BAMR_RELEARN_CYC)))
      relearn_d = 1'b1;
  end

  // broadcast scheduler
  always_comb
  begin
    state_d     = state_q;
    alarm_gap_d = (sec_tick && !alarm_ok) ? alarm_gap_q + 6'h01 : alarm_gap_q;
    chg_gap_d   = (sec_tick && !chg_ok) ? chg_gap_q + 6'h01 : chg_gap_q;
    case (state_q)
      BAMR_IDLE:
      begin
        if (!alarm_off && alarm_ok && (cap_alarm || time_alarm))
        begin
          state_d     = BAMR_ALARM;
          alarm_gap_d = 6'h00;
        end
        else if (!alarm_off && !chg_off && chg_ok)
        begin
          state_d   = BAMR_CHG_I;
          chg_gap_d = 6'h00;
        end
      end
      BAMR_ALARM:
        if (mst_done_in)
          state_d = BAMR_IDLE;
      BAMR_CHG_I:
        if (mst_done_in)
          state_d = BAMR_CHG_V;
      BAMR_CHG_V:
        if (mst_done_in)
          state_d = BAMR_IDLE;
      default:
        state_d = BAMR_IDLE;
    endcase
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      cap_thr_q   <= 16'h0000;
      time_thr_q  <= 16'h0000;
      mode_hi_q   <= 3'b000;
      relearn_q   <= 1'b1;
      cyc_cnt_q   <= 5'h00;
      presc_q     <= 32'h0000_0000;
      supp_s_q    <= 6'h00;
      alarm_gap_q <= `BAMR_BCAST_GAP_S + 6'h01;
      chg_gap_q   <= `BAMR_BCAST_GAP_S + 6'h01;
      state_q     <= BAMR_IDLE;
    end
    else
    begin
      cap_thr_q   <= cap_thr_d;
      time_thr_q  <= time_thr_d;
      mode_hi_q   <= mode_hi_d;
      relearn_q   <= relearn_d;
      cyc_cnt_q   <= cyc_cnt_d;
      presc_q     <= presc_d;
      supp_s_q    <= supp_s_d;
      alarm_gap_q <= alarm_gap_d;
      chg_gap_q   <= chg_gap_d;
      state_q     <= state_d;
    end
  end

  // next master message: fields captured on state entry, held while requested
  always_comb
  begin
    req_d   = (state_d != BAMR_IDLE) && !(mst_done_in && req_q && (state_d == state_q));
    addr_d  = addr_q;
    mcmd_d  = mcmd_q;
    mdata_d = mdata_q;
    if (state_d != state_q)
    begin
      case (state_d)
        BAMR_ALARM:
        begin
          addr_d  = `BAMR_HOST_ADDR;
          mcmd_d  = `BAMR_CMD_ALARM;
          mdata_d = warn_word;
        end
        BAMR_CHG_I:
        begin
          addr_d  = `BAMR_CHGR_ADDR;
          mcmd_d  = `BAMR_CMD_CHG_CUR;
          mdata_d = charge_current_request_in;
        end
        BAMR_CHG_V:
        begin
          addr_d  = `BAMR_CHGR_ADDR;
          mcmd_d  = `BAMR_CMD_CHG_VOLT;
          mdata_d = charge_voltage_request_in;
        end
        default:
        begin
          addr_d  = addr_q;
          mcmd_d  = mcmd_q;
          mdata_d = mdata_q;
        end
      endcase
    end
  end

  // registered answers and master message
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      done_q  <= 1'b0;
      ack_q   <= 1'b0;
      rdata_q <= 16'h0000;
      req_q   <= 1'b0;
      addr_q  <= 7'h00;
      mcmd_q  <= 8'h00;
      mdata_q <= 16'h0000;
    end
    else
    begin
      done_q  <= to_me;
      ack_q   <= hit_any;
      rdata_q <= (hit_any && !cmd_write_in) ? rd_mux : rdata_q;
      req_q   <= req_d;
      addr_q  <= addr_d;
      mcmd_q  <= mcmd_d;
      mdata_q <= mdata_d;
    end
  end

  assign cmd_done_out       = done_q;
  assign cmd_ack_out        = ack_q;
  assign cmd_rdata_out      = rdata_q;
  assign mst_req_out        = req_q;
  assign mst_addr_out       = addr_q;
  assign mst_cmd_out        = mcmd_q;
  assign mst_data_out       = mdata_q;
  assign capacity_units_out = mode_hi_q[2];

endmodule : bamr_top

// [verif/bamr_chk.sv]
// assertions on the ports of bamr_top
// bound below; CYC_PER_SEC follows the instance
`timescale 1ns/10ps
module bamr_chk #(
  parameter int unsigned CYC_PER_SEC = 20
)
(
  // watched ports
  input wire logic        clk_in,
  input wire logic        rst_in,
  input wire logic        cmd_valid_in,
  input wire logic        cmd_write_in,
  input wire logic [6:0]  cmd_addr_in,
  input wire logic [7:0]  cmd_code_in,
  input wire logic        cmd_done_out,
  input wire logic        cmd_ack_out,
  input wire logic [15:0] cmd_rdata_out,
  input wire logic        mst_req_out,
  input wire logic [6:0]  mst_addr_out,
  input wire logic [7:0]  mst_cmd_out,
  input wire logic [15:0] mst_data_out,
  input wire logic        mst_done_in
);
  localparam int GAP = 10 * CYC_PER_SEC - 1;
  logic sel;
  logic map;
  logic alm;
  int   gap_q;
  assign sel = cmd_valid_in && cmd_addr_in == 7'h0B;
  assign map = cmd_code_in inside {[8'h01:8'h03]};
  assign alm = mst_req_out && mst_cmd_out == 8'h16;
  // cycles since an alarm began, saturating
  always_ff @(posedge clk_in or posedge rst_in)
    if (rst_in)
      gap_q <= GAP;
    else
      gap_q <= (alm && $rose(mst_req_out)) ? 0 : gap_q + int'(gap_q < GAP);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  done_sel_a: assert property (sel |=> cmd_done_out) else $error("no done");
  done_only_a: assert property (!sel |=> !cmd_done_out) else $error("stray done");
  ack_code_a: assert property (sel |=> cmd_ack_out == $past(map)) else $error("bad ack");
  mode_fixed_a: assert property (sel && !cmd_write_in && cmd_code_in == 8'h03
    |=> (cmd_rdata_out & 16'h037F) == 16'h0000) else $error("mode fixed bits");
  req_hold_a: assert property (mst_req_out && !mst_done_in
    |=> mst_req_out && $stable({mst_addr_out, mst_cmd_out, mst_data_out})) else $error("req moved");
  req_drop_a: assert property (mst_req_out && mst_done_in && mst_cmd_out != 8'h14
    |=> !mst_req_out) else $error("req held");
  pair_next_a: assert property (mst_req_out && mst_done_in && mst_cmd_out == 8'h14
    |=> mst_req_out && mst_cmd_out == 8'h15) else $error("no voltage message");
  alarm_dest_a: assert property (alm |-> mst_addr_out == 7'h10) else $error("alarm dest");
  charge_dest_a: assert property (mst_req_out && !alm
    |-> mst_addr_out == 7'h12 && mst_cmd_out inside {8'h14, 8'h15}) else $error("charge dest");
  alarm_gap_a: assert property ($rose(alm) |-> gap_q >= GAP) else $error("alarm too soon");
  cover property ($rose(alm));
  cover property (mst_req_out && mst_cmd_out == 8'h15);
  cover property (sel && cmd_write_in && cmd_code_in == 8'h03);
endmodule : bamr_chk
bind bamr_top bamr_chk #(.CYC_PER_SEC(CYC_PER_SEC)) u_chk (.clk_in, .rst_in, .cmd_valid_in,
  .cmd_write_in, .cmd_addr_in, .cmd_code_in, .cmd_done_out, .cmd_ack_out, .cmd_rdata_out,
  .mst_req_out, .mst_addr_out, .mst_cmd_out, .mst_data_out, .mst_done_in);

// [verif/bamr_smbus_model.sv]
// far-side smbus engine: finishes each master write word wait_in+1 cycles after the request
// assumes the block's master port on the same clock
`timescale 1ns/10ps
module bamr_smbus_model (
  // clock, reset, master port of the block
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  input  wire logic [3:0] wait_in,
  input  wire logic       mst_req_in,
  output logic            mst_done_out
);
  logic [3:0] cnt_q;
  always_ff @(posedge clk_in or posedge rst_in)
    if (rst_in)
    begin
      cnt_q        <= 4'h0;
      mst_done_out <= 1'b0;
    end
    else
    begin
      mst_done_out <= mst_req_in && !mst_done_out && cnt_q >= wait_in;
      cnt_q        <= (mst_req_in && !mst_done_out) ? cnt_q + 4'h1 : 4'h0;
    end
endmodule : bamr_smbus_model

// [verif/test_battery_alarm_mode_regs.sv]
// bench for the alarm and mode register bank, random data from a fixed seed
// far side is bamr_smbus_model; 20 cycles stand for one second
`timescale 1ns/10ps
module test_battery_alarm_mode_regs;
  localparam int unsigned CPS = 20;
  logic        clk_in = 1'b0, rst_in = 1'b1, cmd_valid_in = 1'b0, cmd_write_in = 1'b0;
  logic [6:0]  cmd_addr_in = 7'h0B, mst_addr_out;
  logic [7:0]  cmd_code_in = 8'h00, mst_cmd_out;
  logic [5:0]  ev = 6'h00;
  logic [3:0]  wt = 4'h0;
  logic [15:0] cmd_wdata_in = 16'h0000, nv_t = 16'h0000, nv_c = 16'h0000, rem = 16'hFFFF;
  logic [15:0] avg = 16'hFFFF, cmd_rdata_out, mst_data_out, al_d, rd, v;
  logic        cmd_done_out, cmd_ack_out, mst_req_out, mst_done_in, capacity_units_out, dn;
  int          fails = 0, num_checks = 0, n_al = 0, n_ch = 0, a0, c0;
  always #10 clk_in = ~clk_in;
  bamr_top #(.CYC_PER_SEC(CPS)) u_dut (.clk_in, .rst_in, .init_load_in(ev[0]),
    .nv_time_thr_in(nv_t), .nv_cap_thr_in(nv_c), .full_reset_in(ev[1]), .cycle_count_in(ev[2]),
    .fcc_update_in(ev[3]), .learn_done_in(ev[4]), .sleep_in(ev[5]),
    .remaining_capacity_value_in(rem), .average_time_to_empty_in(avg),
    .charge_current_request_in(16'h0BB8), .charge_voltage_request_in(16'h3138), .cmd_valid_in,
    .cmd_write_in, .cmd_addr_in, .cmd_code_in, .cmd_wdata_in, .cmd_done_out, .cmd_ack_out,
    .cmd_rdata_out, .mst_req_out, .mst_addr_out, .mst_cmd_out, .mst_data_out, .mst_done_in,
    .capacity_units_out);
  bamr_smbus_model u_far (.clk_in, .rst_in, .wait_in(wt), .mst_req_in(mst_req_out),
    .mst_done_out(mst_done_in));
  always @(posedge clk_in)
    if (mst_req_out && mst_done_in)
      if (mst_cmd_out == 8'h16)
      begin
        n_al++;
        al_d = mst_data_out;
      end
      else
      begin
        n_ch++;
        chk("chg_data", mst_data_out, (mst_cmd_out == 8'h14) ? 16'h0BB8 : 16'h3138);
      end
  task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d);
    @(posedge clk_in);
    cmd_valid_in <= 1'b1;
    cmd_write_in <= w;
    cmd_code_in  <= c;
    cmd_wdata_in <= d;
    @(posedge clk_in);
    cmd_valid_in <= 1'b0;
    #1;
    dn = cmd_done_out;
    rd = {cmd_rdata_out[15:1], cmd_rdata_out[0]};
    v  = (c == 8'h04) ? {14'h0000, dn, cmd_ack_out} : v;
  endtask : xfer
  task automatic rdx(input string nm, input logic [7:0] c, input logic [15:0] e);
    xfer(1'b0, c, 16'h0000);
    chk(nm, rd, e);
  endtask : rdx
  task automatic pulse(input logic [5:0] m);
    @(posedge clk_in);
    ev <= m;
    @(posedge clk_in);
    ev <= 6'h00;
  endtask : pulse
  task automatic secs(input int n);
    repeat (n * CPS) @(posedge clk_in);
  endtask : secs
  function automatic logic [15:0] mode_exp(input logic [15:0] w, input logic rl);
    return {w[15:13], 5'h00, rl, 7'h00};
  endfunction : mode_exp
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : tally_and_finish
  initial
  begin
    v = $urandom(32'h8783);
    repeat (20) @(posedge clk_in);
    rst_in <= 1'b0;
    rdx("mode", 8'h03, 16'h0080);
    nv_t <= 16'($urandom);
    nv_c <= 16'($urandom);
    pulse(6'h01);
    rdx("cap_thr", 8'h01, nv_c);
    rdx("time_thr", 8'h02, nv_t);
    repeat (6)
    begin
      v = $urandom;
      wt <= 4'($urandom);
      xfer(1'b1, 8'h03, v);
      rdx("mode_wr", 8'h03, mode_exp(v, 1'b1));
      chk("units", {15'h0000, capacity_units_out}, {15'h0000, v[15]});
      xfer(1'b1, 8'h01, ~v);
      rdx("cap_wr", 8'h01, ~v);
      xfer(1'b1, 8'h02, v ^ 16'h5A5A);
      rdx("time_wr", 8'h02, v ^ 16'h5A5A);
    end
    pulse(6'h20);
    rdx("sleep", 8'h03, 16'h0080);
    pulse(6'h18);
    rdx("learned", 8'h03, 16'h0000);
    repeat (10) pulse(6'h04);
    pulse(6'h08);
    repeat (19) pulse(6'h04);
    rdx("cyc19", 8'h03, 16'h0000);
    pulse(6'h04);
    rdx("cyc20", 8'h03, 16'h0080);
    pulse(6'h10);
    rdx("relearn_clr", 8'h03, 16'h0000);
    pulse(6'h18);
    pulse(6'h12);
    rdx("set_wins", 8'h03, 16'h0080);
    xfer(1'b1, 8'h04, 16'h1234);
    chk("unmapped", v, 16'h0002);
    cmd_addr_in <= 7'h0C;
    xfer(1'b1, 8'h01, 16'h0000);
    chk("other_addr", {15'h0000, dn}, 16'h0000);
    cmd_addr_in <= 7'h0B;
    $display("test registers done");
    xfer(1'b1, 8'h02, 16'h0000);
    xfer(1'b1, 8'h01, 16'h0064);
    rem <= 16'h0032;
    avg <= 16'h0005;
    secs(4);
    chk("cap_alarm", al_d & 16'h0300, 16'h0200);
    xfer(1'b1, 8'h01, 16'h0000);
    secs(1);
    a0 = n_al;
    secs(25);
    chk("zero_thr", 16'(n_al - a0), 16'h0000);
    xfer(1'b1, 8'h02, 16'h000A);
    secs(12);
    chk("time_alarm", al_d & 16'h0300, 16'h0100);
    xfer(1'b1, 8'h03, 16'h2000);
    secs(2);
    a0 = n_al;
    c0 = n_ch;
    secs(56);
    chk("suppressed", 16'(n_al - a0 + n_ch - c0), 16'h0000);
    xfer(1'b1, 8'h03, 16'h2000);
    secs(12);
    chk("kept_off", 16'(n_al - a0 + n_ch - c0), 16'h0000);
    secs(50);
    chk("resumed", 16'(n_al > a0), 16'h0001);
    xfer(1'b1, 8'h03, 16'h4000);
    secs(2);
    a0 = n_al;
    c0 = n_ch;
    secs(24);
    chk("chg_off", 16'(n_ch - c0), 16'h0000);
    chk("alarm_on", 16'(n_al > a0), 16'h0001);
    xfer(1'b1, 8'h03, 16'h0000);
    secs(25);
    chk("chg_on", 16'(n_ch > c0), 16'h0001);
    $display("test broadcasts done");
    tally_and_finish();
  end
  initial
  begin
    #(20 * 9000);
    fails++;
    tally_and_finish();
  end
endmodule : test_battery_alarm_mode_regs
